// ==== vhau_unit.sv ====
// Vector hash-assist datapath: SHA-2 schedule expansion and SM3 rounds.
//
// Summary of operation
// - Decode schedule-expand op by funct6 101101.
// - Decode SM3 compress op by funct6 101011.
// - Schedule op needs SEW 32, or 64.
// - Schedule op reserved if vd overlaps sources.
// - Fixed word packing across vd, vs2, vs1.
// - SEW selects SHA-256 or SHA-512 expansion.
// - New word from sigmas and older words.
// - Words 18, 19 reuse fresh 16, 17.
// - Sigma zero 32: rotr 7, 18, shr 3.
// - Sigma zero 64: rotr 1, 8, shr 7.
// - Sigma one 32: rotr 17, 19, shr 10.
// - Sigma one 64: rotr 19, 61, shr 6.
// - Walk groups from vstart to vl.
// - Too-narrow group: illegal, fail, no write.
// - Schedule words are little-endian, unswapped.
// - SM3 reserved unless SEW 32, no vs2 overlap.
// - SM3 reads state and message words 0,1,4,5.
// - SM3 byte-reverses every input word.
// - SM3 byte-reverses all eight output words.
// - Immediate k selects rounds 2k and 2k+1.
// - Exactly two SM3 rounds per group.
// - SM3 constant by round, rotated by index.
// - SM3 boolean functions switch after round 15.
// - Permutation P0: x, rotl 9, rotl 17.
// - Round computes ss1, ss2, tt1, tt2.
`timescale 1ns/10ps
`default_nettype none
module vhau_unit
  import vhau_pkg::*;
#(
  parameter bit SHA512_EN = 1'b1,
  parameter int IDX_W = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic issue_valid,
  input wire vhau_issue_t issue,
  output logic issue_ready,
  output logic rd_req,
  output logic [IDX_W-1:0] rd_group,
  input wire logic rd_valid,
  input wire vhau_operand_t rd_data,
  output logic wr_valid,
  output logic [IDX_W-1:0] wr_group,
  output logic [255:0] wr_data,
  output logic done,
  output var vhau_status_t status
);

  if (IDX_W < VHAU_LEN_W - 2 || IDX_W > VHAU_LEN_W) begin : g_chk
    $error("IDX_W cannot hold the group index range");
  end

  // ----------------------------------------------------------------------
  // Word functions
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rotr32(input logic [31:0] x, input int n);
    return (x >> n) | (x << (32 - n));
  endfunction

  function automatic logic [31:0] rotl32(input logic [31:0] x, input int n);
    return (x << n) | (x >> (32 - n));
  endfunction

  function automatic logic [63:0] rotr64(input logic [63:0] x, input int n);
    return (x >> n) | (x << (64 - n));
  endfunction

  function automatic logic [31:0] small_sigma_zero_32(input logic [31:0] x);
    return rotr32(x, S256_S0_R1) ^ rotr32(x, S256_S0_R2) ^ (x >> S256_S0_SH);
  endfunction

  function automatic logic [31:0] small_sigma_one_32(input logic [31:0] x);
    return rotr32(x, S256_S1_R1) ^ rotr32(x, S256_S1_R2) ^ (x >> S256_S1_SH);
  endfunction

  function automatic logic [63:0] small_sigma_zero_64(input logic [63:0] x);
    return rotr64(x, S512_S0_R1) ^ rotr64(x, S512_S0_R2) ^ (x >> S512_S0_SH);
  endfunction

  function automatic logic [63:0] small_sigma_one_64(input logic [63:0] x);
    return rotr64(x, S512_S1_R1) ^ rotr64(x, S512_S1_R2) ^ (x >> S512_S1_SH);
  endfunction

  function automatic logic [31:0] rev8(input logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  function automatic logic regs_overlap(input logic [4:0] a,
                                        input logic [4:0] b,
                                        input logic [3:0] n);
    logic [5:0] ae;
    logic [5:0] be;
    ae = {1'b0, a} + {2'b00, n};
    be = {1'b0, b} + {2'b00, n};
    return ({1'b0, a} < be) && ({1'b0, b} < ae);
  endfunction

  // Words pass through untouched: the datapath is little-endian by design.
  function automatic logic [127:0] sha256_ms(input logic [127:0] d,
                                             input logic [127:0] s2,
                                             input logic [127:0] s1);
    logic [31:0] w16;
    logic [31:0] w17;
    logic [31:0] w18;
    logic [31:0] w19;
    w16 = small_sigma_one_32(s1[95:64]) + s2[63:32] + small_sigma_zero_32(d[63:32]) + d[31:0];
    w17 = small_sigma_one_32(s1[127:96]) + s2[95:64] + small_sigma_zero_32(d[95:64]) + d[63:32];
    w18 = small_sigma_one_32(w16) + s2[127:96] + small_sigma_zero_32(d[127:96]) + d[95:64];
    w19 = small_sigma_one_32(w17) + s1[31:0] + small_sigma_zero_32(s2[31:0]) + d[127:96];
    return {w19, w18, w17, w16};
  endfunction

  function automatic logic [255:0] sha512_ms(input logic [255:0] d,
                                             input logic [255:0] s2,
                                             input logic [255:0] s1);
    logic [63:0] w16;
    logic [63:0] w17;
    logic [63:0] w18;
    logic [63:0] w19;
    w16 = small_sigma_one_64(s1[191:128]) + s2[127:64] + small_sigma_zero_64(d[127:64]) + d[63:0];
    w17 = small_sigma_one_64(s1[255:192]) + s2[191:128] + small_sigma_zero_64(d[191:128]) + d[127:64];
    w18 = small_sigma_one_64(w16) + s2[255:192] + small_sigma_zero_64(d[255:192]) + d[191:128];
    w19 = small_sigma_one_64(w17) + s1[63:0] + small_sigma_zero_64(s2[63:0]) + d[255:192];
    return {w19, w18, w17, w16};
  endfunction

  function automatic logic [31:0] sm3_p0(input logic [31:0] x);
    return x ^ rotl32(x, SM3_P0_R1) ^ rotl32(x, SM3_P0_R2);
  endfunction

  function automatic logic [255:0] sm3_round(input logic [255:0] s,
                                             input logic [5:0] j,
                                             input logic [31:0] w,
                                             input logic [31:0] x);
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] f;
    logic [31:0] g;
    logic [31:0] h;
    logic [31:0] t;
    logic [31:0] ff;
    logic [31:0] gg;
    logic [31:0] ss1;
    logic [31:0] ss2;
    logic [31:0] tt1;
    logic [31:0] tt2;
    {h, g, f, e, d, c, b, a} = s;
    if (j <= SM3_SPLIT_ROUND) begin
      t = SM3_T_LO;
      ff = a ^ b ^ c;
      gg = e ^ f ^ g;
    end else begin
      t = SM3_T_HI;
      ff = (a & b) | (a & c) | (b & c);
      gg = (e & f) | (~e & g);
    end
    ss1 = rotl32(rotl32(a, SM3_A_ROT) + e + rotl32(t, int'(j[4:0])),
                 SM3_SS1_ROT);
    ss2 = ss1 ^ rotl32(a, SM3_A_ROT);
    tt1 = ff + d + ss2 + x;
    tt2 = gg + h + ss1 + w;
    return {g, rotl32(f, SM3_F_ROT), e, sm3_p0(tt2),
            c, rotl32(b, SM3_B_ROT), a, tt1};
  endfunction

  function automatic logic [255:0] sm3_two_rounds(input logic [255:0] vd,
                                                  input logic [255:0] m,
                                                  input logic [4:0] k);
    logic [255:0] st;
    logic [255:0] r;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w4;
    logic [31:0] w5;
    for (int i = 0; i < 8; i++) begin
      st[i*32 +: 32] = rev8(vd[i*32 +: 32]);
    end
    w0 = rev8(m[31:0]);
    w1 = rev8(m[63:32]);
    w4 = rev8(m[159:128]);
    w5 = rev8(m[191:160]);
    st = sm3_round(st, {k, 1'b0}, w0, w0 ^ w4);
    st = sm3_round(st, {k, 1'b1}, w1, w1 ^ w5);
    for (int i = 0; i < 8; i++) begin
      r[i*32 +: 32] = rev8(st[i*32 +: 32]);
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Decode and legality of the held instruction
  // ----------------------------------------------------------------------
  vhau_state_t state_reg;
  vhau_state_t state_next;
  vhau_issue_t issue_reg;
  vhau_operand_t op_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [IDX_W-1:0] end_reg;
  logic [255:0] result;
  logic base_ok;
  logic is_sha;
  logic is_sm3;
  logic known;
  logic sew32;
  logic sew64;
  logic ovl_vs1;
  logic ovl_vs2;
  logic resv;
  logic narrow;
  logic [15:0] element_group_width;
  logic [15:0] eg_start;
  logic [15:0] eg_end;

  always_comb begin
    base_ok = issue_reg.instr[25] && issue_reg.instr[14:12] == VHAU_VECTOR_MASK_VECTOR_FUNCTION_CLASS &&
              issue_reg.instr[6:0] == VHAU_OPVE;
    is_sha = base_ok && issue_reg.instr[31:26] == VHAU_F6_SHA2MS;
    is_sm3 = base_ok && issue_reg.instr[31:26] == VHAU_F6_SM3C;
    known = is_sha || is_sm3;
    sew32 = issue_reg.vsew == VHAU_SEW32;
    sew64 = issue_reg.vsew == VHAU_SEW64;
    ovl_vs1 = regs_overlap(issue_reg.instr[11:7], issue_reg.instr[19:15],
                           issue_reg.group_regs);
    ovl_vs2 = regs_overlap(issue_reg.instr[11:7], issue_reg.instr[24:20],
                           issue_reg.group_regs);
    if (is_sm3) begin
      resv = !sew32 || ovl_vs2;
      element_group_width = VHAU_EGW_SM3;
      eg_start = issue_reg.vstart >> VHAU_EGS_SM3_LOG2;
      eg_end = issue_reg.vl >> VHAU_EGS_SM3_LOG2;
    end else begin
      resv = !(sew32 || (SHA512_EN && sew64)) || ovl_vs1 || ovl_vs2;
      element_group_width = sew64 ? VHAU_EGW_SHA512 : VHAU_EGW_SHA256;
      eg_start = issue_reg.vstart >> VHAU_EGS_SHA_LOG2;
      eg_end = issue_reg.vl >> VHAU_EGS_SHA_LOG2;
    end
    narrow = issue_reg.lmul_vlen < element_group_width;
  end

  always_comb begin
    if (is_sm3) begin
      result = sm3_two_rounds(op_reg.vd, op_reg.vs2, issue_reg.instr[19:15]);
    end else if (sew64) begin
      result = sha512_ms(op_reg.vd, op_reg.vs2, op_reg.vs1);
    end else begin
      result = {128'h0, sha256_ms(op_reg.vd[127:0], op_reg.vs2[127:0],
                                  op_reg.vs1[127:0])};
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (issue_valid && issue_ready) begin
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!known || resv || narrow) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_NEXT;
        end
      end
      ST_NEXT: begin
        state_next = (idx_reg < end_reg) ? ST_READ : ST_DONE;
      end
      ST_READ: begin
        if (rd_valid) begin
          state_next = ST_CALC;
        end
      end
      ST_CALC: begin
        state_next = ST_NEXT;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      issue_ready <= 1'b0;
    end else begin
      state_reg <= state_next;
      issue_ready <= state_next == ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      issue_reg <= '0;
      op_reg <= '0;
    end else begin
      if (state_reg == ST_IDLE && issue_valid && issue_ready) begin
        issue_reg <= issue;
      end
      if (state_reg == ST_READ && rd_valid) begin
        op_reg <= rd_data;
      end
    end
  end

  // The index is cut to IDX_W; the elaboration check keeps vl/4 in range.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      idx_reg <= '0;
      end_reg <= '0;
    end else if (state_reg == ST_CHECK) begin
      idx_reg <= eg_start[IDX_W-1:0];
      end_reg <= eg_end[IDX_W-1:0];
    end else if (state_reg == ST_CALC) begin
      idx_reg <= idx_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_req <= 1'b0;
      rd_group <= '0;
    end else begin
      rd_req <= state_reg == ST_NEXT && idx_reg < end_reg;
      if (state_reg == ST_NEXT) begin
        rd_group <= idx_reg;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_valid <= 1'b0;
      wr_group <= '0;
      wr_data <= '0;
    end else begin
      wr_valid <= state_reg == ST_CALC;
      if (state_reg == ST_CALC) begin
        wr_group <= idx_reg;
        wr_data <= result;
      end
    end
  end

  // Status stands from done until the next instruction is checked, one cycle after it is accepted.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      done <= 1'b0;
      status <= '0;
    end else begin
      done <= state_next == ST_DONE;
      if (state_reg == ST_CHECK) begin
        status.unknown <= !known;
        status.reserved <= known && resv;
        status.illegal <= known && (resv || narrow);
        status.success <= known && !resv && !narrow;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_decode;
    @(posedge clock) disable iff (!nrst)
    (done && !status.unknown) |-> issue_reg.instr[25] &&
      issue_reg.instr[6:0] == VHAU_OPVE &&
      issue_reg.instr[14:12] == VHAU_VECTOR_MASK_VECTOR_FUNCTION_CLASS &&
      (issue_reg.instr[31:26] == VHAU_F6_SHA2MS ||
       issue_reg.instr[31:26] == VHAU_F6_SM3C);
  endproperty
  a_decode: assert property (p_decode)
    else $error("done reported a known op for a foreign encoding");

  property p_sha_resv;
    @(posedge clock) disable iff (!nrst)
    (state_reg == ST_CHECK && is_sha && (ovl_vs1 || !(sew32 || sew64)))
      |=> done && status.reserved && !status.success;
  endproperty
  a_sha_resv: assert property (p_sha_resv)
    else $error("reserved schedule encoding was not refused");

  property p_sm3_resv;
    @(posedge clock) disable iff (!nrst)
    (state_reg == ST_CHECK && is_sm3 && (ovl_vs2 || !sew32))
      |=> done && status.reserved;
  endproperty
  a_sm3_resv: assert property (p_sm3_resv)
    else $error("reserved SM3 encoding was not refused");

  property p_narrow;
    @(posedge clock) disable iff (!nrst)
    (state_reg == ST_CHECK && known && narrow)
      |=> (done && status.illegal && !status.success && !wr_valid)
      ##1 (!wr_valid && !rd_req);
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("narrow group did not fail cleanly");

  property p_group_range;
    @(posedge clock) disable iff (!nrst)
    rd_req |-> rd_group < end_reg ##[1:1000] (wr_valid && wr_group == rd_group);
  endproperty
  a_group_range: assert property (p_group_range)
    else $error("group index out of range or not written back");

  property p_sha256_chain;
    @(posedge clock) disable iff (!nrst)
    (wr_valid && is_sha && sew32) |-> wr_data[95:64] ==
      32'(small_sigma_one_32(wr_data[31:0]) + op_reg.vs2[127:96] +
          small_sigma_zero_32(op_reg.vd[127:96]) + op_reg.vd[95:64]);
  endproperty
  a_sha256_chain: assert property (p_sha256_chain)
    else $error("SHA-256 word 18 does not follow word 16");

  property p_sha512_chain;
    @(posedge clock) disable iff (!nrst)
    (wr_valid && is_sha && sew64) |-> wr_data[255:192] ==
      64'(small_sigma_one_64(wr_data[127:64]) + op_reg.vs1[63:0] +
          small_sigma_zero_64(op_reg.vs2[63:0]) + op_reg.vd[255:192]);
  endproperty
  a_sha512_chain: assert property (p_sha512_chain)
    else $error("SHA-512 word 19 does not follow word 17");

  property p_sm3_shift;
    @(posedge clock) disable iff (!nrst)
    (wr_valid && is_sm3) |->
      rev8(wr_data[95:64]) == rotl32(rev8(op_reg.vd[31:0]), SM3_B_ROT) &&
      rev8(wr_data[127:96]) == rotl32(rev8(op_reg.vd[63:32]), SM3_B_ROT) &&
      rev8(wr_data[223:192]) == rotl32(rev8(op_reg.vd[159:128]), SM3_F_ROT) &&
      rev8(wr_data[255:224]) == rotl32(rev8(op_reg.vd[191:160]), SM3_F_ROT);
  endproperty
  a_sm3_shift: assert property (p_sm3_shift)
    else $error("SM3 state words not shifted through two rounds");

  property p_one_write;
    @(posedge clock) disable iff (!nrst)
    wr_valid |=> !wr_valid;
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("more than one write for a group");

endmodule
`default_nettype wire

// ==== vhau_pkg.sv ====
// Shared constants and carrier types for the vector hash-assist unit.
package vhau_pkg;

  // ----------------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------------
  localparam logic [5:0] VHAU_F6_SHA2MS = 6'h2d;
  localparam logic [5:0] VHAU_F6_SM3C = 6'h2b;
  localparam logic [2:0] VHAU_VECTOR_MASK_VECTOR_FUNCTION_CLASS = 3'h2;
  localparam logic [6:0] VHAU_OPVE = 7'h77;
  localparam logic [2:0] VHAU_SEW32 = 3'h2;
  localparam logic [2:0] VHAU_SEW64 = 3'h3;

  // ----------------------------------------------------------------------
  // Group geometry
  // ----------------------------------------------------------------------
  localparam int VHAU_LEN_W = 16;
  localparam logic [15:0] VHAU_EGW_SHA256 = 16'h0080;
  localparam logic [15:0] VHAU_EGW_SHA512 = 16'h0100;
  localparam logic [15:0] VHAU_EGW_SM3 = 16'h0100;
  localparam int VHAU_EGS_SHA_LOG2 = 2;
  localparam int VHAU_EGS_SM3_LOG2 = 3;

  // ----------------------------------------------------------------------
  // SHA-2 schedule sigma amounts
  // ----------------------------------------------------------------------
  localparam int S256_S0_R1 = 7;
  localparam int S256_S0_R2 = 18;
  localparam int S256_S0_SH = 3;
  localparam int S256_S1_R1 = 17;
  localparam int S256_S1_R2 = 19;
  localparam int S256_S1_SH = 10;
  localparam int S512_S0_R1 = 1;
  localparam int S512_S0_R2 = 8;
  localparam int S512_S0_SH = 7;
  localparam int S512_S1_R1 = 19;
  localparam int S512_S1_R2 = 61;
  localparam int S512_S1_SH = 6;

  // ----------------------------------------------------------------------
  // SM3 round constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] SM3_T_LO = 32'h79cc_4519;
  localparam logic [31:0] SM3_T_HI = 32'h7a87_9d8a;
  localparam logic [5:0] SM3_SPLIT_ROUND = 6'h0f;
  localparam int SM3_P0_R1 = 9;
  localparam int SM3_P0_R2 = 17;
  localparam int SM3_A_ROT = 12;
  localparam int SM3_SS1_ROT = 7;
  localparam int SM3_B_ROT = 9;
  localparam int SM3_F_ROT = 19;

  typedef struct packed {
    logic [31:0] instr;
    logic [2:0] vsew;
    logic [15:0] vstart;
    logic [15:0] vl;
    logic [15:0] lmul_vlen;
    logic [3:0] group_regs;
  } vhau_issue_t;

  typedef struct packed {
    logic [255:0] vd;
    logic [255:0] vs1;
    logic [255:0] vs2;
  } vhau_operand_t;

  typedef struct packed {
    logic success;
    logic illegal;
    logic reserved;
    logic unknown;
  } vhau_status_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CHECK = 6'h02,
    ST_NEXT = 6'h04,
    ST_READ = 6'h08,
    ST_CALC = 6'h10,
    ST_DONE = 6'h20
  } vhau_state_t;

endpackage

// ==== vhau_regfile_model.sv ====
// Behavioural register file that answers the unit's operand reads.
`timescale 1ns/10ps
`default_nettype none
module vhau_regfile_model
  import vhau_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic rd_req,
  input wire logic [15:0] rd_group,
  input wire vhau_operand_t src,
  input wire logic slow,
  output logic rd_valid,
  output var vhau_operand_t rd_data
);
  logic busy_reg;
  logic [1:0] wait_reg;
  logic [15:0] grp_reg;
  vhau_operand_t data_reg;
  // Outside an answer the lines carry the inverse of the last value, so a
  // unit that samples late picks up wrong operands.
  assign rd_data = rd_valid ? data_reg : ~data_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'd0;
      grp_reg <= 16'h0000;
      rd_valid <= 1'b0;
      data_reg <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (rd_req) begin
        busy_reg <= 1'b1;
        wait_reg <= slow ? 2'd3 : 2'd0;
        grp_reg <= rd_group;
      end else if (busy_reg && wait_reg != 2'd0) begin
        wait_reg <= wait_reg - 2'd1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        rd_valid <= 1'b1;
        data_reg <= src ^ 768'(grp_reg);
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the vector hash-assist unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vhau_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic issue_valid = 1'b0;
  logic slow = 1'b0;
  vhau_issue_t issue = '0;
  vhau_operand_t src = '0;
  logic issue_ready, rd_req, rd_valid, wr_valid, done;
  logic [15:0] rd_group, wr_group;
  logic [255:0] wr_data;
  logic [271:0] wexp;
  vhau_operand_t rd_data;
  vhau_status_t status;
  logic [271:0] wq [$];
  logic [3:0] sq [$];
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 12;
  always #10 clock = ~clock;
  vhau_unit vhau_unit_i (.clock(clock), .nrst(nrst),
    .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
    .rd_req(rd_req), .rd_group(rd_group), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_valid(wr_valid), .wr_group(wr_group),
    .wr_data(wr_data), .done(done), .status(status));
  vhau_regfile_model vhau_regfile_model_i (.clock(clock), .nrst(nrst),
    .rd_req(rd_req), .rd_group(rd_group), .src(src), .slow(slow),
    .rd_valid(rd_valid), .rd_data(rd_data));
  // ----------------------------------------------------------------------
  // Reference arithmetic
  // ----------------------------------------------------------------------
  function automatic logic [63:0] ror(logic [63:0] x, int n, bit b);
    logic [31:0] y;
    y = x[31:0];
    y = (y >> n) | (y << (32 - n));
    return b ? ((x >> n) | (x << (64 - n))) : {32'h0000_0000, y};
  endfunction
  function automatic logic [63:0] sg(logic [63:0] x, bit b, bit one);
    if (one) begin
      return b ? ror(x, 19, b) ^ ror(x, 61, b) ^ (x >> 6)
               : ror(x, 17, b) ^ ror(x, 19, b) ^ (x >> 10);
    end
    return b ? ror(x, 1, b) ^ ror(x, 8, b) ^ (x >> 7)
             : ror(x, 7, b) ^ ror(x, 18, b) ^ (x >> 3);
  endfunction
  function automatic logic [63:0] el(logic [255:0] v, int k, bit b);
    return b ? v[64*k+:64] : 64'(v[32*k+:32]);
  endfunction
  function automatic logic [255:0] sha_ref(bit b, vhau_operand_t o);
    logic [63:0] w [20];
    logic [63:0] m;
    m = b ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
    for (int k = 0; k < 4; k++) begin
      w[k] = el(o.vd, k, b);
    end
    w[4] = el(o.vs2, 0, b);
    for (int k = 1; k < 4; k++) begin
      w[8+k] = el(o.vs2, k, b);
    end
    w[12] = el(o.vs1, 0, b);
    w[14] = el(o.vs1, 2, b);
    w[15] = el(o.vs1, 3, b);
    for (int t = 16; t < 20; t++) begin
      w[t] = (sg(w[t-2], b, 1) + w[t-7] + sg(w[t-15], b, 0) + w[t-16]) & m;
    end
    if (b) begin
      return {w[19], w[18], w[17], w[16]};
    end
    return {128'h0, w[19][31:0], w[18][31:0], w[17][31:0], w[16][31:0]};
  endfunction
  function automatic logic [31:0] rol(logic [31:0] x, int n);
    return (x << n) | (x >> (32 - n));
  endfunction
  function automatic logic [31:0] rv(logic [31:0] x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction
  function automatic logic [255:0] sm3_ref(vhau_operand_t o, int k);
    logic [31:0] s [8];
    logic [31:0] w [8];
    logic [31:0] s1, s2, t1, t2, f, g;
    logic [255:0] r;
    int j;
    for (int i = 0; i < 8; i++) begin
      s[i] = rv(o.vd[32*i+:32]);
      w[i] = rv(o.vs2[32*i+:32]);
    end
    for (int n = 0; n < 2; n++) begin
      j = 2 * k + n;
      t1 = (j <= 15) ? 32'h79cc_4519 : 32'h7a87_9d8a;
      s1 = rol(rol(s[0], 12) + s[4] + rol(t1, j % 32), 7);
      s2 = s1 ^ rol(s[0], 12);
      f = (j <= 15) ? s[0] ^ s[1] ^ s[2]
                    : (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
      g = (j <= 15) ? s[4] ^ s[5] ^ s[6] : (s[4] & s[5]) | (~s[4] & s[6]);
      t1 = f + s[3] + s2 + (w[n] ^ w[n+4]);
      t2 = g + s[7] + s1 + w[n];
      s[3] = s[2];
      s[2] = rol(s[1], 9);
      s[1] = s[0];
      s[0] = t1;
      s[7] = s[6];
      s[6] = rol(s[5], 19);
      s[5] = s[4];
      s[4] = t2 ^ rol(t2, 9) ^ rol(t2, 17);
    end
    for (int i = 0; i < 8; i++) begin
      r[32*i+:32] = rv(s[i]);
    end
    return r;
  endfunction
  // ----------------------------------------------------------------------
  // Driver and monitor
  // ----------------------------------------------------------------------
  task automatic mismatch(string msg);
    $display("mismatch at %0t: %s", $time, msg);
    fails++;
  endtask
  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] enc(logic [5:0] f6, logic [4:0] s2,
      logic [4:0] s1, logic [4:0] d);
    return {f6, 1'b1, s2, s1, VHAU_VECTOR_MASK_VECTOR_FUNCTION_CLASS, d, VHAU_OPVE};
  endfunction
  // A refused op pushes no write, so any write it makes is caught.
  task automatic run_op(logic [31:0] ins, logic [2:0] sew, int vs, int vl,
      logic [15:0] lv, logic [3:0] st);
    int element_group_size;
    int n;
    bit hit;
    vhau_operand_t o;
    for (int j = 0; j < 24; j++) begin
      src[32*j+:32] = $random(seed);
    end
    element_group_size = (ins[31:26] == VHAU_F6_SM3C) ? 8 : 4;
    for (int g = vs / element_group_size; st == 4'b1000 && g < vl / element_group_size; g++) begin
      o = src ^ 768'(g);
      wq.push_back({16'(g), (element_group_size == 8) ? sm3_ref(o, ins[19:15])
                                       : sha_ref(sew == VHAU_SEW64, o)});
    end
    sq.push_back(st);
    issue <= '{ins, sew, 16'(vs), 16'(vl), lv, 4'h1};
    issue_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      hit = (issue_ready === 1'b1);
      #1;
    end while (!hit);
    issue_valid <= 1'b0;
    do begin
      @(posedge clock);
      hit = (done === 1'b1);
      #1;
      n++;
    end while (!hit && n < 300);
    if (!hit || wq.size() != 0) mismatch("writes missing");
  endtask
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      fails++;
      end_of_test();
    end
    if (wr_valid === 1'b1) begin
      tests_run++;
      wexp = (wq.size() == 0) ? '1 : wq.pop_front();
      if ({wr_group, wr_data} !== wexp) mismatch("write");
    end
    if (done === 1'b1) begin
      tests_run++;
      if (sq.size() == 0 || status !== sq.pop_front()) mismatch("status");
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    #1;
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    run_op(enc(6'h2d, 2, 3, 1), 3'h2, 4, 13, 16'h0080,
      4'b1000);
    slow <= 1'b1;
    run_op(enc(6'h2d, 2, 3, 1), 3'h3, 0, 8, 16'h0100,
      4'b1000);
    run_op(enc(6'h2b, 2, 7, 1), 3'h2, 0, 16, 16'h0100,
      4'b1000);
    slow <= 1'b0;
    run_op(enc(6'h2b, 2, 8, 1), 3'h2, 8, 23, 16'h0100, 4'b1000);
    run_op(enc(6'h2b, 2, 31, 1), 3'h2, 0, 8, 16'h0200, 4'b1000);
    run_op(enc(6'h2b, 2, 5'($random(seed)), 1), 3'h2, 0, 8, 16'h0100,
      4'b1000);
    run_op(enc(6'h2d, 2, 3, 1), 3'h0, 0, 4, 16'h0100, 4'b0110);
    run_op(enc(6'h2d, 2, 1, 1), 3'h2, 0, 4, 16'h0100, 4'b0110);
    run_op(enc(6'h2d, 1, 3, 1), 3'h3, 0, 4, 16'h0100, 4'b0110);
    run_op(enc(6'h2b, 2, 0, 1), 3'h3, 0, 8, 16'h0100, 4'b0110);
    run_op(enc(6'h2b, 1, 0, 1), 3'h2, 0, 8, 16'h0100, 4'b0110);
    run_op(enc(6'h2d, 2, 3, 1), 3'h2, 0, 4, 16'h0040, 4'b0100);
    run_op(enc(6'h2d, 2, 3, 1), 3'h3, 0, 4, 16'h0080, 4'b0100);
    run_op(enc(6'h2b, 2, 0, 1), 3'h2, 0, 8, 16'h0080, 4'b0100);
    run_op(enc(6'h2d, 2, 3, 1) ^ 32'h0200_0000, 3'h2, 0, 4, 16'h0100,
      4'b0001);
    run_op(enc(6'h2e, 2, 3, 1), 3'h2, 0, 4, 16'h0100, 4'b0001);
    end_of_test();
  end
endmodule
`default_nettype wire
